// *** design/io_select_cfg.svh ***
// Purpose: constants for the i/o select and wait logic
// Assumes: 125 MHz system clock, 9-bit i/o address
// Notes:   addresses are full byte addresses, bit 0 ignored
`ifndef IO_SELECT_CFG_SVH
`define IO_SELECT_CFG_SVH

// address decode
`define IO_ADDR_W        9
`define ADDR_INTC_LO     9'h000
`define ADDR_INTC_HI     9'h002
`define ADDR_FLOPPY_LO   9'h040
`define ADDR_FLOPPY_HI   9'h046
`define ADDR_PAR_LO      9'h048
`define ADDR_PAR_HI      9'h04E
`define ADDR_PAR_CTRL    9'h04E
`define ADDR_SOUND_LO    9'h050
`define ADDR_SOUND_HI    9'h056
`define ADDR_TIMER_LO    9'h058
`define ADDR_TIMER_HI    9'h05E
`define ADDR_TIMER_CTRL  9'h05E
`define ADDR_SERIAL_LO   9'h060
`define ADDR_SERIAL_HI   9'h066
`define ADDR_DISP_LO     9'h068
`define ADDR_DISP_HI     9'h06E
`define ADDR_DMA_LO      9'h070
`define ADDR_DMA_HI      9'h076
`define ADDR_LOCAL_LO    9'h078
`define ADDR_LOCAL_HI    9'h07E
`define ADDR_EXP_LO      9'h080
`define ADDR_EXP_HI      9'h1FF

// select vector bit positions
`define SEL_INTC         0
`define SEL_FLOPPY       1
`define SEL_PAR          2
`define SEL_SOUND        3
`define SEL_TIMER        4
`define SEL_SERIAL       5
`define SEL_DISP         6
`define SEL_DMA1         7
`define SEL_DMA2         8
`define SEL_EXP          9
`define SEL_W            10

// bus control bit positions
`define CTL_REQ          0
`define CTL_RD           1
`define CTL_WR           2
`define CTL_LOCK         3
`define CTL_SRAM         4
`define CTL_MWR          5
`define CTL_W            6

// pin bit positions
`define PIN_OSC          0
`define PIN_ACK          1
`define PIN_BUSY         2
`define PIN_FAULT        3
`define PIN_SRDY         4
`define PIN_TOUT         5
`define PIN_W            6

// timing
`define SYS_CLK_MHZ      125
`define WAIT_STATE_NS    200
`define WAIT_STATE_CYC   ((`WAIT_STATE_NS * `SYS_CLK_MHZ) / 1000)
`define PCLK_KHZ         2500
`define PCLK_HALF_CYC    ((`SYS_CLK_MHZ * 1000) / (2 * `PCLK_KHZ))
`define SERIAL_WAITS     5
`define SRAM_WAITS       1
`define OSC_DIV_FAST     2
`define OSC_DIV_SLOW     16

`endif

// *** design/io_select_pkg.sv ***
// Purpose: types for the i/o select and wait logic
// Assumes: io_select_cfg.svh supplies widths
// Notes:   state of each module is one packed struct
`include "io_select_cfg.svh"

package io_select_pkg;

  typedef enum logic {CYC_IDLE, CYC_ACTIVE} cycle_t;

  typedef struct packed {
    logic [`IO_ADDR_W-1:0] addr_m;
    logic [`IO_ADDR_W-1:0] addr_s;
    logic [`CTL_W-1:0]     ctl_m;
    logic [`CTL_W-1:0]     ctl_s;
    logic [`PIN_W-1:0]     pin_m;
    logic [`PIN_W-1:0]     pin_s;
    logic                  osc_prev;
    cycle_t                cyc;
    logic [`SEL_W-1:0]     sel;
    logic [1:0]            idx;
    logic                  disp_ctrl;
    logic                  lock_q;
    logic [2:0]            prn;
    logic                  dma_rdy;
    logic                  tirq;
    logic                  sram_we;
    logic                  screen;
  } top_state_t;

endpackage : io_select_pkg

// *** design/wait_if.sv ***
// Purpose: carries start, tick and busy of a wait-state chain
// Assumes: one clock shared by both ends
// Notes:   start and tick are one-cycle pulses
`timescale 1ns/1ns

interface wait_if;
  logic start;
  logic tick;
  logic busy;
  modport chain (input start, input tick, output busy);
  modport user  (output start, output tick, input busy);
endinterface : wait_if

// *** design/clock_divider.sv ***
// Purpose: toggles a clock after a set number of step pulses
// Assumes: step_i is synchronous to clk_i, one step per cycle it is high
// Notes:   tick_o pulses on each toggle
`timescale 1ns/1ns

module clock_divider #(
  parameter int HALF = 2
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // step and outputs
  input  wire logic step_i,
  output logic      clk_o,
  output logic      tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;

  // rollover on the last step of a half period
  assign tick_o = step_i && (state_reg.cnt == 8'(HALF - 1));
  assign clk_o  = state_reg.clk;

  // count steps and flip the output
  always_comb
  begin
    state_next = state_reg;
    if (tick_o)
    begin
      state_next.cnt = 8'h00;
      state_next.clk = ~state_reg.clk;
    end
    else if (step_i)
      state_next.cnt = state_reg.cnt + 8'h01;
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule : clock_divider

// *** design/wait_chain.sv ***
// Purpose: shift-register chain that holds busy for n wait states
// Assumes: tick marks the end of each wait state
// Notes:   a start while busy reloads the chain
`timescale 1ns/1ns

module wait_chain #(
  parameter int STAGES = 1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // chain control
  wait_if.chain     w
);
  typedef struct packed {
    logic [STAGES-1:0] sr;
  } chain_state_t;

  chain_state_t state_reg;
  chain_state_t state_next;

  assign w.busy = |state_reg.sr;

  // load ones on start, shift one stage per tick
  always_comb
  begin
    state_next = state_reg;
    if (w.start)
      state_next.sr = '1;
    else if (w.tick)
      state_next.sr = state_reg.sr >> 1;
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule : wait_chain

// *** design/io_select_wait.sv ***
// Purpose: i/o chip selects, wait states and derived clocks
// Assumes: bus and pins asynchronous, passed through two flops
// Notes:   selects lag the bus by the sync and one register
//          wait ticks come from the free-running serial clock divider,
//          so the first wait state of an access may be short
`timescale 1ns/1ns
`include "io_select_cfg.svh"

module io_select_wait
  import io_select_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // processor i/o bus
  input  wire logic [`IO_ADDR_W-1:0] io_addr_i,
  input  wire logic                  io_req_i,
  input  wire logic                  io_rd_i,
  input  wire logic                  io_wr_i,
  input  wire logic                  lock_i,
  // static ram access
  input  wire logic                  sram_sel_i,
  input  wire logic                  mem_wr_i,
  // pins from oscillator, printer, peripherals
  input  wire logic                  osc_4mhz_i,
  input  wire logic                  printer_ack_i,
  input  wire logic                  printer_busy_i,
  input  wire logic                  printer_fault_i,
  input  wire logic                  serial_ready_i,
  input  wire logic                  timer_out0_i,
  // chip selects
  output logic                       interrupt_controller_select_o,
  output logic                       floppy_select_o,
  output logic                       parallel_select_o,
  output logic                       sound_select_o,
  output logic                       timer_select_o,
  output logic                       serial_select_o,
  output logic                       display_select_o,
  output logic                       display_ctrl_reg_o,
  output logic [1:0]                 dma_channel_attention_o,
  output logic                       expansion_select_o,
  output logic [1:0]                 reg_index_o,
  // ready inputs of the clock generator
  output logic                       ready_input_one_o,
  output logic                       ready_input_two_o,
  // derived clocks
  output logic                       serial_clock_o,
  output logic                       counter_one_clock_o,
  output logic                       counter_two_clock_o,
  output logic                       counter_zero_clock_o,
  // serial controller and dma side
  output logic                       serial_lock_o,
  output logic [2:0]                 serial_printer_o,
  output logic                       dma_ready_o,
  output logic                       timer_irq_o,
  // static ram control
  output logic                       sram_write_enable_o,
  output logic                       sram_screen_o
);

  top_state_t state_reg;
  top_state_t state_next;

  logic [`IO_ADDR_W-1:0] a;
  logic [`SEL_W-1:0]     dec;
  logic                  rd;
  logic                  wr;
  logic                  req;
  logic                  cyc_start;
  logic                  osc_rise;
  logic                  fast_clk;
  logic                  wait_tick;
  logic                  sram_start;

  wait_if serial_w ();
  wait_if sram_w ();

  // synchronised bus view, bit 0 dropped
  // even addresses only
  assign a   = {state_reg.addr_s[`IO_ADDR_W-1:1], 1'b0};
  assign req = state_reg.ctl_s[`CTL_REQ];
  assign rd  = state_reg.ctl_s[`CTL_RD];
  assign wr  = state_reg.ctl_s[`CTL_WR];

  // new i/o cycle and oscillator edge
  assign cyc_start = req && (state_reg.cyc == CYC_IDLE);
  assign osc_rise  = state_reg.pin_s[`PIN_OSC] && !state_reg.osc_prev;

  // address decode of the current cycle
  always_comb
  begin
    dec = '0;
    if (a == `ADDR_INTC_LO || a == `ADDR_INTC_HI)
      dec[`SEL_INTC] = 1'b1;
    if (a >= `ADDR_FLOPPY_LO && a <= `ADDR_FLOPPY_HI)
      dec[`SEL_FLOPPY] = 1'b1;
    if (a >= `ADDR_PAR_LO && a <= `ADDR_PAR_HI
        && !(a == `ADDR_PAR_CTRL && rd))
      dec[`SEL_PAR] = 1'b1;
    if (a >= `ADDR_SOUND_LO && a <= `ADDR_SOUND_HI && wr)
      dec[`SEL_SOUND] = 1'b1;
    if (a >= `ADDR_TIMER_LO && a <= `ADDR_TIMER_HI
        && !(a == `ADDR_TIMER_CTRL && rd))
      dec[`SEL_TIMER] = 1'b1;
    if (a >= `ADDR_SERIAL_LO && a <= `ADDR_SERIAL_HI)
      dec[`SEL_SERIAL] = 1'b1;
    if (a >= `ADDR_DISP_LO && a <= `ADDR_DISP_HI)
      dec[`SEL_DISP] = 1'b1;
    if (a >= `ADDR_DMA_LO && a <= `ADDR_DMA_HI)
      dec[a[1] ? `SEL_DMA2 : `SEL_DMA1] = 1'b1;
    if (a >= `ADDR_EXP_LO && a <= `ADDR_EXP_HI
        && !(a >= `ADDR_LOCAL_LO && a <= `ADDR_LOCAL_HI))
      dec[`SEL_EXP] = 1'b1;
    // no strobe, no select
    if (!req || !(rd || wr))
      dec = '0;
  end

  // next state
  always_comb
  begin
    state_next = state_reg;

    // two-flop synchronisers on every outside input
    // the address must be steady before req is raised
    state_next.addr_m = io_addr_i;
    state_next.addr_s = state_reg.addr_m;
    state_next.ctl_m  = {mem_wr_i, sram_sel_i, lock_i,
                         io_wr_i, io_rd_i, io_req_i};
    state_next.ctl_s  = state_reg.ctl_m;
    state_next.pin_m  = {timer_out0_i, serial_ready_i,
                         printer_fault_i, printer_busy_i,
                         printer_ack_i, osc_4mhz_i};
    state_next.pin_s  = state_reg.pin_m;
    state_next.osc_prev = state_reg.pin_s[`PIN_OSC];

    // cycle tracker for start detection
    // a new cycle starts only after req has been seen low
    if (cyc_start)
      state_next.cyc = CYC_ACTIVE;
    else if (!req)
      state_next.cyc = CYC_IDLE;

    // registered selects
    state_next.sel       = dec;
    state_next.disp_ctrl = a[1];
    // index picks counter 0, 1, 2 or control
    state_next.idx       = a[2:1];

    state_next.lock_q = state_reg.ctl_s[`CTL_LOCK];
    state_next.prn = {state_reg.pin_s[`PIN_FAULT],
                      state_reg.pin_s[`PIN_BUSY],
                      state_reg.pin_s[`PIN_ACK]};
    state_next.dma_rdy = state_reg.pin_s[`PIN_SRDY];
    // counter 0 output raises the timer request
    state_next.tirq    = state_reg.pin_s[`PIN_TOUT];

    // write enable and mux toward screen when idle
    state_next.sram_we = state_reg.ctl_s[`CTL_SRAM]
                         && state_reg.ctl_s[`CTL_MWR];
    state_next.screen  = !state_reg.ctl_s[`CTL_SRAM];
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg        <= '0;
      state_reg.cyc    <= CYC_IDLE;
      state_reg.screen <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // serial clock from the system clock
  // toggles every half period, even duty
  clock_divider #(
    .HALF (`PCLK_HALF_CYC)
  ) u_serial_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .step_i (1'b1),
    .clk_o  (serial_clock_o),
    .tick_o (wait_tick)
  );

  // oscillator halved for counters 1 and 2
  clock_divider #(
    .HALF (`OSC_DIV_FAST / 2)
  ) u_fast_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .step_i (osc_rise),
    .clk_o  (fast_clk),
    .tick_o ()
  );

  // oscillator over 16 for counter 0
  clock_divider #(
    .HALF (`OSC_DIV_SLOW / 2)
  ) u_slow_clk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .step_i (osc_rise),
    .clk_o  (counter_zero_clock_o),
    .tick_o ()
  );

  assign counter_one_clock_o = fast_clk;
  assign counter_two_clock_o = fast_clk;

  assign serial_w.start = cyc_start && dec[`SEL_SERIAL];
  assign serial_w.tick  = wait_tick;

  wait_chain #(
    .STAGES (`SERIAL_WAITS)
  ) u_serial_wait (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .w     (serial_w.chain)
  );

  // single stage on static ram accesses
  // rising edge of the synced select: the registered screen flag holds the inverted
  // select of one cycle back, so no logic reads the first sync flop
  assign sram_start   = state_reg.ctl_s[`CTL_SRAM] && state_reg.screen;
  assign sram_w.start = sram_start;
  assign sram_w.tick  = wait_tick;

  wait_chain #(
    .STAGES (`SRAM_WAITS)
  ) u_sram_wait (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .w     (sram_w.chain)
  );

  // ready one for memory, ready two for i/o
  // ready drops already in the start cycle, before the chain loads
  assign ready_input_one_o = !(sram_w.busy || sram_start);
  assign ready_input_two_o = !(serial_w.busy || serial_w.start);

  // registered outputs
  assign interrupt_controller_select_o = state_reg.sel[`SEL_INTC];
  assign floppy_select_o         = state_reg.sel[`SEL_FLOPPY];
  assign parallel_select_o       = state_reg.sel[`SEL_PAR];
  assign sound_select_o          = state_reg.sel[`SEL_SOUND];
  assign timer_select_o          = state_reg.sel[`SEL_TIMER];
  assign serial_select_o         = state_reg.sel[`SEL_SERIAL];
  assign display_select_o        = state_reg.sel[`SEL_DISP];
  assign display_ctrl_reg_o      = state_reg.disp_ctrl;
  assign dma_channel_attention_o = {state_reg.sel[`SEL_DMA2],
                                    state_reg.sel[`SEL_DMA1]};
  assign expansion_select_o      = state_reg.sel[`SEL_EXP];
  assign reg_index_o             = state_reg.idx;

  // pass-through to serial controller, dma and interrupts, then static ram control
  assign serial_lock_o       = state_reg.lock_q;
  assign serial_printer_o    = state_reg.prn;
  assign dma_ready_o         = state_reg.dma_rdy;
  assign timer_irq_o         = state_reg.tirq;
  assign sram_write_enable_o = state_reg.sram_we;
  assign sram_screen_o       = state_reg.screen;

endmodule : io_select_wait

// *** testbench/io_select_wait_monitor.sv ***
// Purpose: port assertions for the i/o select and wait block
// Assumes: inputs steady four cycles count as settled
// Notes:   bound into every io_select_wait instance
`timescale 1ns/1ns
`include "io_select_cfg.svh"

module io_select_wait_monitor (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // bus and pins
  input wire logic [`IO_ADDR_W-1:0] io_addr_i,
  input wire logic                  io_req_i,
  input wire logic                  io_rd_i,
  input wire logic                  io_wr_i,
  input wire logic                  lock_i,
  input wire logic                  sram_sel_i,
  input wire logic                  mem_wr_i,
  input wire logic                  printer_ack_i,
  input wire logic                  printer_busy_i,
  input wire logic                  printer_fault_i,
  input wire logic                  serial_ready_i,
  // watched outputs
  input wire logic                  parallel_select_o,
  input wire logic                  sound_select_o,
  input wire logic                  serial_select_o,
  input wire logic                  expansion_select_o,
  input wire logic                  ready_input_one_o,
  input wire logic                  ready_input_two_o,
  input wire logic                  serial_clock_o,
  input wire logic                  serial_lock_o,
  input wire logic [2:0]            serial_printer_o,
  input wire logic                  dma_ready_o,
  input wire logic                  sram_write_enable_o,
  input wire logic                  sram_screen_o
);
  logic [18:0] ins;
  logic [18:0] ins_reg;
  logic [2:0]  calm_reg;
  logic [7:0]  half_reg;
  logic        sclk_reg;
  logic        seen_reg;
  logic        calm;
  logic        act;

  // inputs watched for settling
  assign ins = {io_addr_i, io_req_i, io_rd_i, io_wr_i, lock_i, sram_sel_i,
                mem_wr_i, printer_ack_i, printer_busy_i, printer_fault_i,
                serial_ready_i};
  assign calm = (calm_reg >= 3'h4) && (ins == ins_reg);
  assign act = calm && io_req_i && (io_rd_i || io_wr_i);

  // settle counter and serial clock half period
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ins_reg  <= '0;
      calm_reg <= 3'h0;
      half_reg <= 8'h00;
      sclk_reg <= 1'b0;
      seen_reg <= 1'b0;
    end
    else
    begin
      ins_reg  <= ins;
      calm_reg <= (ins != ins_reg) ? 3'h0 :
                  ((calm_reg == 3'h7) ? 3'h7 : calm_reg + 3'h1);
      half_reg <= (serial_clock_o != sclk_reg) ? 8'h00 :
                  ((half_reg == 8'hFF) ? 8'hFF : half_reg + 8'h01);
      sclk_reg <= serial_clock_o;
      seen_reg <= seen_reg || (serial_clock_o != sclk_reg);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_par_ctl;
    act && io_rd_i && io_addr_i[8:1] == 8'h27 |-> !parallel_select_o;
  endproperty
  a_par_ctl: assert property (p_par_ctl) else $error("par read");
  property p_sound_rd;
    act && io_rd_i && io_addr_i[8:3] == 6'h0A |-> !sound_select_o;
  endproperty
  a_sound_rd: assert property (p_sound_rd) else $error("snd read");
  property p_serial_sel;
    act && io_addr_i[8:3] == 6'h0C |-> serial_select_o && !expansion_select_o;
  endproperty
  a_serial_sel: assert property (p_serial_sel) else $error("ser");
  property p_exp;
    act && io_addr_i >= 9'h080 |-> expansion_select_o;
  endproperty
  a_exp: assert property (p_exp) else $error("exp sel");
  property p_ser_wait;
    $rose(serial_select_o) |-> !ready_input_two_o;
  endproperty
  a_ser_wait: assert property (p_ser_wait) else $error("no wait");
  property p_ser_hold;
    $fell(ready_input_two_o) |-> !ready_input_two_o [*8];
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("short");
  property p_sclk;
    seen_reg && (serial_clock_o != sclk_reg) |-> half_reg == 8'h18;
  endproperty
  a_sclk: assert property (p_sclk) else $error("sclk half");
  property p_pass;
    calm |-> serial_lock_o == lock_i && dma_ready_o == serial_ready_i &&
      serial_printer_o == {printer_fault_i, printer_busy_i, printer_ack_i};
  endproperty
  a_pass: assert property (p_pass) else $error("pins");
  property p_sram;
    calm |-> sram_write_enable_o == (sram_sel_i && mem_wr_i) &&
      sram_screen_o == !sram_sel_i;
  endproperty
  a_sram: assert property (p_sram) else $error("sram ctl");
  property p_sram_wait;
    $fell(ready_input_one_o) |-> ##[1:26] ready_input_one_o;
  endproperty
  a_sram_wait: assert property (p_sram_wait) else $error("sram");
endmodule : io_select_wait_monitor

bind io_select_wait io_select_wait_monitor u_mon (.*);

// *** testbench/io_host_model.sv ***
// Purpose: host processor i/o bus model
// Assumes: cycle ends once ready is seen high
// Notes:   released address shows the inverted last value
`timescale 1ns/1ns

module io_host_model (
  // clock and ready
  input  wire logic       clk_i,
  input  wire logic       ready_i,
  // bus
  output logic [8:0]      addr_o,
  output logic            req_o,
  output logic            rd_o,
  output logic            wr_o
);
  // idle bus at start
  initial
  begin
    addr_o = 9'h000;
    req_o  = 1'b0;
    rd_o   = 1'b0;
    wr_o   = 1'b0;
  end

  // one cycle; n counts cycles spent waiting
  task automatic io_cycle(input logic [8:0] a, input logic w, output int n);
    n = 0;
    @(posedge clk_i);
    #1;
    addr_o = a;
    req_o  = 1'b1;
    rd_o   = !w;
    wr_o   = w;
    repeat (6) @(posedge clk_i);
    #1;
    while (ready_i !== 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    @(posedge clk_i);
    #1;
    req_o  = 1'b0;
    rd_o   = 1'b0;
    wr_o   = 1'b0;
    addr_o = ~a;
    repeat (2) @(posedge clk_i);
  endtask : io_cycle
endmodule : io_host_model

// *** testbench/test_io_select_wait.sv ***
// Purpose: self-checking bench for the i/o select and wait block
// Assumes: host model runs bus cycles, bench drives the pins
// Notes:   4 MHz oscillator runs free, unrelated in phase
`timescale 1ns/1ns
`include "io_select_cfg.svh"
`define CHECK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s expected %0h seen %0h", \
  nm, e, g); end end

module test_io_select_wait
  import io_select_pkg::*;
;
  logic       clk_i, rst_i, io_req_i, io_rd_i, io_wr_i, lock_i;
  logic [8:0] io_addr_i;
  logic       sram_sel_i, mem_wr_i, osc_4mhz_i, printer_ack_i;
  logic       printer_busy_i, printer_fault_i, serial_ready_i, timer_out0_i;
  logic       interrupt_controller_select_o, floppy_select_o;
  logic       parallel_select_o, sound_select_o, timer_select_o;
  logic       serial_select_o, display_select_o, display_ctrl_reg_o;
  logic [1:0] dma_channel_attention_o, reg_index_o;
  logic       expansion_select_o, ready_input_one_o, ready_input_two_o;
  logic       serial_clock_o, counter_one_clock_o, counter_two_clock_o;
  logic       counter_zero_clock_o, serial_lock_o, dma_ready_o, timer_irq_o;
  logic [2:0] serial_printer_o;
  logic       sram_write_enable_o, sram_screen_o;
  logic [4:0] prev;
  int         num_errors, n_tests, n_osc, n_sc, n_hi, n_c0, n_c1, n_c2;

  io_select_wait u_dut (.*);
  io_host_model u_host (.clk_i(clk_i), .ready_i(ready_input_two_o),
    .addr_o(io_addr_i), .req_o(io_req_i), .rd_o(io_rd_i), .wr_o(io_wr_i));

  // clocks: system and oscillator
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // odd toggle times keep oscillator edges off the clock edges
  initial
  begin
    osc_4mhz_i = 1'b0;
    #1;
    forever
    begin
      #124 osc_4mhz_i = 1'b1;
      #126 osc_4mhz_i = 1'b0;
    end
  end

  // rising edge counters of the oscillator and derived clocks, serial clock high count
  always @(posedge clk_i)
  begin
    n_osc += (osc_4mhz_i && !prev[0]);
    n_sc += (serial_clock_o && !prev[1]);
    n_c0 += (counter_zero_clock_o && !prev[2]);
    n_c1 += (counter_one_clock_o && !prev[3]);
    n_c2 += (counter_two_clock_o && !prev[4]);
    n_hi += serial_clock_o;
    prev <= {counter_two_clock_o, counter_one_clock_o, counter_zero_clock_o,
             serial_clock_o, osc_4mhz_i};
  end

  // expected selects, waits aside
  function automatic logic [12:0] exp_sel(input logic [8:0] a, input logic w);
    logic [12:0] v;
    v = 13'h0000;
    v[0] = (a[8:2] == 7'h00);
    v[1] = (a[8:3] == 6'h08);
    v[2] = (a[8:3] == 6'h09) && (w || a[2:1] != 2'h3);
    v[3] = (a[8:3] == 6'h0A) && w;
    v[4] = (a[8:3] == 6'h0B) && (w || a[2:1] != 2'h3);
    v[5] = (a[8:3] == 6'h0C);
    v[6] = (a[8:3] == 6'h0D);
    v[7] = v[6] && a[1];
    v[8] = (a[8:3] == 6'h0E) && !a[1];
    v[9] = (a[8:3] == 6'h0E) && a[1];
    v[10] = (a >= 9'h080);
    v[12:11] = a[2:1];
    return v;
  endfunction : exp_sel

  // every even address read, odd neighbour written
  task automatic decode_sweep;
    logic [12:0] e, g;
    logic [8:0]  a;
    int          n;
    for (int i = 0; i < 512; i++)
    begin
      a = 9'(i);
      e = exp_sel(a, a[0]);
      fork
        u_host.io_cycle(a, a[0], n);
        begin
          repeat (6) @(posedge clk_i);
          #2;
          g = {reg_index_o, expansion_select_o, dma_channel_attention_o,
               display_ctrl_reg_o & display_select_o, display_select_o,
               serial_select_o, timer_select_o, sound_select_o,
               parallel_select_o, floppy_select_o,
               interrupt_controller_select_o};
        end
      join
      `CHECK("selects", e, g)
      `CHECK("waits", {e[5], !e[5]}, {n > 90 && n < 127, n == 0})
      // wait bound used up: stop here
      if (n >= 400)
        report_and_stop;
    end
  endtask : decode_sweep

  // every pattern of the copied pins
  task automatic pins_run;
    for (int p = 0; p < 64; p++)
    begin
      @(posedge clk_i);
      #1;
      {lock_i, printer_fault_i, printer_busy_i, printer_ack_i,
       serial_ready_i, timer_out0_i} = 6'(p);
      repeat (6) @(posedge clk_i);
      #2;
      `CHECK("pins", 6'(p), {serial_lock_o, serial_printer_o, dma_ready_o,
             timer_irq_o})
    end
  endtask : pins_run

  // static ram read then write
  task automatic sram_run;
    int n;
    for (int w = 0; w < 2; w++)
    begin
      n = 0;
      @(posedge clk_i);
      #1;
      sram_sel_i = 1'b1;
      mem_wr_i = w[0];
      repeat (40)
      begin
        @(posedge clk_i);
        #2;
        n += (ready_input_one_o === 1'b0);
      end
      `CHECK("sram_wait", 1'b1, n >= 1 && n <= 26)
      `CHECK("sram_on", {w[0], 2'h1}, {sram_write_enable_o, sram_screen_o,
             ready_input_two_o})
      @(posedge clk_i);
      #1;
      sram_sel_i = 1'b0;
      mem_wr_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #2;
      `CHECK("sram_off", 3'h3, {sram_write_enable_o, sram_screen_o,
             ready_input_one_o})
    end
  endtask : sram_run

  // derived clock rates over 2000 cycles
  task automatic clocks_run;
    n_osc = 0;
    n_sc = 0;
    n_hi = 0;
    n_c0 = 0;
    n_c1 = 0;
    n_c2 = 0;
    repeat (2000) @(posedge clk_i);
    #2;
    `CHECK("sclk", 1'b1, n_sc >= 39 && n_sc <= 41)
    `CHECK("sclk_duty", 1'b1, n_hi >= 975 && n_hi <= 1025)
    `CHECK("counter_one_clock", 1'b1, n_c1 * 2 - n_osc inside {[-2:2]})
    `CHECK("counter_two_clock", 1'b1, n_c2 * 2 - n_osc inside {[-2:2]})
    `CHECK("clk0", 1'b1, n_c0 * 16 - n_osc inside {[-16:16]})
  endtask : clocks_run

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // hang guard
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop;
  end

  // reset then scenarios
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    prev = 5'h00;
    rst_i = 1'b1;
    {lock_i, sram_sel_i, mem_wr_i, printer_ack_i, printer_busy_i} = 5'h00;
    {printer_fault_i, serial_ready_i, timer_out0_i} = 3'h0;
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    decode_sweep;
    pins_run;
    sram_run;
    clocks_run;
    report_and_stop;
  end
endmodule : test_io_select_wait
